// [core/otp_prog_port.sv]
// Device side of the parallel programming and verification port of the code memory
// Operation
// - Five low pulses of the program strobe commit the presented byte to its location.
// - The encryption table is written with five pulses at addresses zero to 1F.
// - Verify reads return encrypted data only where the key byte chosen by the low five address bits has been written.
// - Each security bit is set by five pulses under that bit's mode levels.
// - With any security bit set, code and encryption table writes are refused.
// - With a security bit set, the remaining security bits can still be set.
// - Three fixed identification bytes can be read back by the programmer.
// - Verified bytes are the exclusive-NOR of the stored byte and one key byte.
module otp_prog_port
   import otp_prog_pkg::*;
#(
   parameter int STROBE_LOW_MIN = STROBE_LOW_MIN_CYC,
   parameter logic [DATA_W-1:0] ID_MAKER = ID_MAKER_DEF,
   parameter logic [DATA_W-1:0] ID_PART = ID_PART_DEF,
   parameter logic [DATA_W-1:0] ID_EXTRA = ID_EXTRA_DEF
) (
   input wire logic clk,                  // System clock, 200 MHz
   input wire logic reset_n,              // Synchronous reset, active low
   input wire pins_t pinsIn,              // Programming pins, asynchronous
   output logic [DATA_W-1:0] port0Out,    // Port 0 output value
   output logic port0Oe_n,                // Port 0 output enable, low drives
   output logic [2:0] securityBits,       // Security fuses, bit 0 is the first
   output logic sixClockMode,             // Six-clock fuse programmed
   output logic writeDone                 // One cycle at each committed write
);

   pins_t pins;
   mode_t mode;
   logic [DATA_W-1:0] codeMem [CODE_DEPTH];
   logic [DATA_W-1:0] keyMem_q [KEY_DEPTH];
   logic [2:0] sb_q;
   logic x2_q;
   logic [2:0] pulseCnt_q;
   logic [LOW_CNT_W-1:0] lowCnt_q;
   logic strobePrev_q;
   logic strobeFall;
   logic strobeRise;
   logic pgmMode;
   logic commit;
   logic locked;
   logic codeWe;
   logic keyWe;
   logic verifyOff;
   logic [DATA_W-1:0] port0_d;
   logic drive_d;

   pin_sync #(.W(PIN_W)) u_sync (
      .clk(clk),
      .reset_n(reset_n),
      .asyncIn(pinsIn),
      .syncOut(pins)
   );

   // Mode decode from the held pin levels
   always_comb begin
      mode = MODE_NONE;
      if (pins.resetLevel && !pins.codeFetchStrobe) begin
         case ({pins.supplyHigh, pins.p27, pins.p26, pins.p37, pins.p36})
            5'b00000: mode = pins.programStrobe ? MODE_READ_SIG : MODE_NONE;
            5'b11011: mode = MODE_PGM_CODE;
            5'b00011: mode = pins.programStrobe ? MODE_VERIFY_CODE : MODE_NONE;
            5'b11010: mode = MODE_PGM_KEY;
            5'b11111: mode = MODE_PGM_SB1;
            5'b11100: mode = MODE_PGM_SB2;
            5'b10101: mode = MODE_PGM_SB3;
            5'b00010: mode = pins.programStrobe ? MODE_VERIFY_SB : MODE_NONE;
            5'b00001: mode = pins.programStrobe && pins.p33 ? MODE_VERIFY_X2 : MODE_NONE;
            default: mode = MODE_NONE;
         endcase
         if ({pins.supplyHigh, pins.p27, pins.p26, pins.p37, pins.p36, pins.p33} == 6'h24) begin
            mode = MODE_PGM_X2;
         end
      end
   end

   assign pgmMode = mode inside {MODE_PGM_CODE, MODE_PGM_KEY, MODE_PGM_SB1, MODE_PGM_SB2,
                                 MODE_PGM_SB3, MODE_PGM_X2};
   assign strobeFall = strobePrev_q && !pins.programStrobe;
   assign strobeRise = !strobePrev_q && pins.programStrobe;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         strobePrev_q <= 1'b1;
      end else begin
         strobePrev_q <= pins.programStrobe;
      end
   end

   // Low-time counter so that short glitches are not counted as pulses
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         lowCnt_q <= '0;
      end else if (pins.programStrobe || !pgmMode) begin
         // Outside program modes, so the strobe catching up after reset is no pulse
         lowCnt_q <= '0;
      end else if (lowCnt_q != {LOW_CNT_W{1'b1}}) begin
         lowCnt_q <= lowCnt_q + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n || !pgmMode) begin
         pulseCnt_q <= '0;
      end else if (commit) begin
         pulseCnt_q <= '0;
      end else if (strobeRise && lowCnt_q >= LOW_CNT_W'(STROBE_LOW_MIN)
                   && pulseCnt_q != 3'h7) begin
         pulseCnt_q <= pulseCnt_q + 3'h1;
      end
   end

   // commit at the end of the fifth long pulse
   assign commit = pgmMode && strobeRise && lowCnt_q >= LOW_CNT_W'(STROBE_LOW_MIN)
                   && pulseCnt_q == PULSES_PER_WRITE - 3'h1;
   // any security fuse locks code and key writes
   assign locked = |sb_q;
   assign codeWe = commit && mode == MODE_PGM_CODE && !locked && pins.addr <= CODE_LAST;
   // key writes limited to the table range
   assign keyWe = commit && mode == MODE_PGM_KEY && !locked && pins.addr <= KEY_LAST;

   always_ff @(posedge clk) begin
      if (codeWe) begin
         codeMem[pins.addr[CODE_IDX_W-1:0]] <= pins.data;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         for (int i = 0; i < KEY_DEPTH; i++) begin
            keyMem_q[i] <= ERASED_BYTE;
         end
      end else if (keyWe) begin
         keyMem_q[pins.addr[KEY_IDX_W-1:0]] <= pins.data;
      end
   end

   // security fuses stay writable once locked
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         sb_q <= 3'h0;
         x2_q <= 1'b0;
      end else if (commit) begin
         if (mode == MODE_PGM_SB1) sb_q[0] <= 1'b1;
         if (mode == MODE_PGM_SB2) sb_q[1] <= 1'b1;
         if (mode == MODE_PGM_SB3) sb_q[2] <= 1'b1;
         if (mode == MODE_PGM_X2 && !locked) x2_q <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         writeDone <= 1'b0;
      end else begin
         writeDone <= codeWe || keyWe || (commit && mode inside {MODE_PGM_SB1, MODE_PGM_SB2,
                      MODE_PGM_SB3}) || (commit && mode == MODE_PGM_X2 && !locked);
      end
   end

   assign verifyOff = sb_q[1] || sb_q[2];

   // Readback value for the current verify mode
   always_comb begin
      port0_d = ERASED_BYTE;
      drive_d = 1'b0;
      case (mode)
         MODE_VERIFY_CODE: begin
            drive_d = !verifyOff;
            // stored byte is mixed with its key byte up to CODE_LAST; above it ERASED_BYTE is read
            if (pins.addr <= CODE_LAST) begin
               port0_d = ~(codeMem[pins.addr[CODE_IDX_W-1:0]] ^
                           keyMem_q[pins.addr[KEY_IDX_W-1:0]]);
            end
         end
         MODE_READ_SIG: begin
            drive_d = 1'b1;
            if (pins.addr == ID_MAKER_ADDR) port0_d = ID_MAKER;
            else if (pins.addr == ID_PART_ADDR) port0_d = ID_PART;
            else if (pins.addr == ID_EXTRA_ADDR) port0_d = ID_EXTRA;
         end
         MODE_VERIFY_SB: begin
            drive_d = 1'b1;
            port0_d = 8'h00;
            port0_d[SB1_POS] = sb_q[0];
            port0_d[SB2_POS] = sb_q[1];
            port0_d[SB3_POS] = sb_q[2];
         end
         MODE_VERIFY_X2: begin
            drive_d = 1'b1;
            port0_d = 8'h00;
            port0_d[X2_POS] = !x2_q;
         end
         default: begin
            drive_d = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         port0Out <= ERASED_BYTE;
         port0Oe_n <= 1'b1;
      end else begin
         port0Out <= port0_d;
         port0Oe_n <= !drive_d;
      end
   end

   assign securityBits = sb_q;
   assign sixClockMode = x2_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   chk_lock_no_code: assert property (locked |-> !codeWe && !keyWe)
      else $error("write accepted while a security bit is set");
   chk_sb_after_lock: assert property (commit && mode == MODE_PGM_SB2 |=> sb_q[1])
      else $error("second security bit not set by its write");
   chk_five_pulses: assert property (codeWe |-> pulseCnt_q == 3'h4 && strobeRise)
      else $error("code written without five pulses");
   chk_sb_needs_pulses: assert property ($rose(sb_q[0]) |-> $past(pulseCnt_q) == 3'h4)
      else $error("security bit set without five pulses");
   chk_key_range: assert property (keyWe |-> pins.addr[ADDR_W-1:KEY_IDX_W] == '0)
      else $error("key write outside table");
   chk_verify_xnor: assert property (mode == MODE_VERIFY_CODE && !verifyOff
      && pins.addr == 16'h0000 ##1 $stable(codeMem[0]) && $stable(keyMem_q[0])
      |-> port0Out == ~(codeMem[0] ^ keyMem_q[0]) && !port0Oe_n)
      else $error("verify byte not mixed with key");
   chk_verify_blocked: assert property (verifyOff && mode == MODE_VERIFY_CODE
      |=> port0Oe_n)
      else $error("verify output while disabled");
   chk_id_maker: assert property (mode == MODE_READ_SIG && pins.addr == ID_MAKER_ADDR
      |=> port0Out == ID_MAKER && !port0Oe_n)
      else $error("maker byte wrong");
   chk_idle_count: assert property (!pgmMode |=> pulseCnt_q == 3'h0 || pgmMode)
      else $error("pulse count kept outside programming");

   cov_code_write: cover property (codeWe);
   cov_key_write: cover property (keyWe);
   cov_sb_write: cover property (commit && mode == MODE_PGM_SB3);
   cov_locked_refuse: cover property (commit && mode == MODE_PGM_CODE && locked);
   cov_x2_write: cover property (commit && mode == MODE_PGM_X2);

endmodule

// [core/otp_prog_pkg.sv]
// Shared constants and types for the one-time-programmable memory programming port
package otp_prog_pkg;

   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int CODE_DEPTH = 16384;
   localparam int CODE_IDX_W = 14;
   localparam logic [ADDR_W-1:0] CODE_LAST = 16'h3fff;
   localparam int KEY_DEPTH = 32;
   localparam int KEY_IDX_W = 5;
   localparam logic [ADDR_W-1:0] KEY_LAST = 16'h001f;
   localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hff;

   // Strobe low pulses that commit one location
   localparam logic [2:0] PULSES_PER_WRITE = 3'h5;

   // Identification bytes and where they read back; values are arbitrary
   localparam logic [ADDR_W-1:0] ID_MAKER_ADDR = 16'h0030;
   localparam logic [ADDR_W-1:0] ID_PART_ADDR = 16'h0031;
   localparam logic [ADDR_W-1:0] ID_EXTRA_ADDR = 16'h0060;
   localparam logic [DATA_W-1:0] ID_MAKER_DEF = 8'ha5;
   localparam logic [DATA_W-1:0] ID_PART_DEF = 8'h3c;
   localparam logic [DATA_W-1:0] ID_EXTRA_DEF = 8'h07;

   // Bit positions on the data port for fuse readback
   localparam int SB1_POS = 7;
   localparam int SB2_POS = 6;
   localparam int SB3_POS = 3;
   localparam int X2_POS = 4;

   // Strobe low time, least accepted figure, in nanoseconds and cycles
   localparam int CLK_PERIOD_NS = 5;
   localparam int STROBE_LOW_MIN_NS = 90000;
   localparam int STROBE_LOW_MIN_CYC = (STROBE_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LOW_CNT_W = 16;

   localparam int PIN_W = 33;

   typedef struct packed {
      logic resetLevel;       // Device reset pin level
      logic codeFetchStrobe;  // Must be low in every programming mode
      logic programStrobe;    // program_strobe_pin
      logic supplyHigh;       // external_access_supply_pin at programming voltage
      logic p27;
      logic p26;
      logic p37;
      logic p36;
      logic p33;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } pins_t;

   typedef enum {
      MODE_NONE, MODE_READ_SIG, MODE_PGM_CODE, MODE_VERIFY_CODE, MODE_PGM_KEY,
      MODE_PGM_SB1, MODE_PGM_SB2, MODE_PGM_SB3, MODE_PGM_X2, MODE_VERIFY_X2,
      MODE_VERIFY_SB
   } mode_t;

endpackage

// [core/pin_sync.sv]
// Three-stage input synchroniser that passes a change once stages two and three agree
module pin_sync #(
   parameter int W = 1
) (
   input wire logic clk,              // System clock
   input wire logic reset_n,          // Synchronous reset, active low
   input wire logic [W-1:0] asyncIn,  // Pins from outside the clock domain
   output logic [W-1:0] syncOut       // Filtered, registered copy
);

   logic [W-1:0] stage1_q;
   logic [W-1:0] stage2_q;
   logic [W-1:0] stage3_q;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         stage1_q <= '0;
         stage2_q <= '0;
         stage3_q <= '0;
      end else begin
         stage1_q <= asyncIn;
         stage2_q <= stage1_q;
         stage3_q <= stage2_q;
      end
   end

   // Each bit follows only once it has held for two samples
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         syncOut <= '0;
      end else begin
         for (int i = 0; i < W; i++) begin
            if (stage2_q[i] == stage3_q[i]) begin
               syncOut[i] <= stage3_q[i];
            end
         end
      end
   end

endmodule

// [verif/prog_model.sv]
// Behavioural programming system that drives mode, address, data and strobe pins
module prog_model
   import otp_prog_pkg::*;
(
   input wire logic clk, // System clock
   output pins_t pinsOut, // Pin levels towards the device
   output logic driveData // High while port 0 is driven here
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      pinsOut = '0;
      pinsOut.resetLevel = 1'b1;
      pinsOut.programStrobe = 1'b1;
      pinsOut.p33 = 1'b1;
      driveData = 1'b0;
   end

   // pins held until the next call
   task automatic setMode(input logic [4:0] m, input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      {pinsOut.supplyHigh, pinsOut.p27, pinsOut.p26, pinsOut.p37, pinsOut.p36} = m;
      pinsOut.addr = a;
      pinsOut.data = d;
      // Port 0 released in read modes so the pull-ups or the device set it
      driveData = m[4];
      repeat (8) @(posedge clk);
      #1;
   endtask

   task automatic setP33(input logic v);
      @(posedge clk);
      #1;
      pinsOut.p33 = v;
      repeat (8) @(posedge clk);
      #1;
   endtask

   task automatic pulses(input int n);
      repeat (n) begin
         @(posedge clk);
         #1;
         pinsOut.programStrobe = 1'b0;
         repeat (8) @(posedge clk);
         #1;
         pinsOut.programStrobe = 1'b1;
         repeat (8) @(posedge clk);
      end
      #1;
   endtask
endmodule

// [verif/tb_otp_prog_port.sv]
// Self-checking bench for the code memory programming port
module tb_otp_prog_port
   import otp_prog_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic clk = 1'b0;
   logic reset_n = 1'b0;
   pins_t modelPins;
   pins_t pinsIn;
   logic driveData;
   logic [DATA_W-1:0] port0Out;
   logic port0Oe_n;
   logic [2:0] securityBits;
   logic sixClockMode;
   logic writeDone;
   int doneCnt = 0;
   int miscompares = 0;
   int compares = 0;

   always #2.5 clk = ~clk;

   always @(posedge clk) begin
      if (writeDone === 1'b1) doneCnt++;
   end

   // Port 0 wire: device drive, else programmer, else pull-ups
   always_comb begin
      pinsIn = modelPins;
      if (port0Oe_n === 1'b0) pinsIn.data = port0Out;
      else if (!driveData) pinsIn.data = 8'hff;
   end

   prog_model model (.clk(clk), .pinsOut(modelPins), .driveData(driveData));

   otp_prog_port #(.STROBE_LOW_MIN(4)) DUT (
      .clk(clk),
      .reset_n(reset_n),
      .pinsIn(pinsIn),
      .port0Out(port0Out),
      .port0Oe_n(port0Oe_n),
      .securityBits(securityBits),
      .sixClockMode(sixClockMode),
      .writeDone(writeDone)
   );

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic expectRead(input logic [4:0] m, input logic [15:0] a, input logic [7:0] exp);
      model.setMode(m, a, 8'h00);
      check("port0Oe_n", {7'h0, port0Oe_n}, 8'h00);
      check("port0Out", port0Out, exp);
   endtask

   task automatic writeLoc(input logic [4:0] m, input logic [15:0] a, input logic [7:0] d,
                           input int n);
      doneCnt = 0;
      model.setMode(m, a, d);
      model.pulses(n);
   endtask

   task automatic test_signature();
      check("securityBits", {5'h0, securityBits}, 8'h00);
      expectRead(5'h00, ID_MAKER_ADDR, ID_MAKER_DEF);
      expectRead(5'h00, ID_PART_ADDR, ID_PART_DEF);
      expectRead(5'h00, ID_EXTRA_ADDR, ID_EXTRA_DEF);
   endtask

   task automatic test_code();
      writeLoc(5'h1b, 16'h0123, 8'h5a, 4);
      check("writeDone", doneCnt[7:0], 8'h00);
      model.pulses(1);
      check("writeDone", doneCnt[7:0], 8'h01);
      expectRead(5'h03, 16'h0123, 8'h5a);
      writeLoc(5'h1b, 16'h0000, 8'h3c, 5);
      check("writeDone", doneCnt[7:0], 8'h01);
      expectRead(5'h03, 16'h0000, 8'h3c);
   endtask

   task automatic test_key();
      writeLoc(5'h1a, 16'h0003, 8'h0f, 5);
      check("writeDone", doneCnt[7:0], 8'h01);
      expectRead(5'h03, 16'h0123, ~(8'h5a ^ 8'h0f));
      writeLoc(5'h1a, 16'h0020, 8'h00, 5);
      check("writeDone", doneCnt[7:0], 8'h00);
      expectRead(5'h03, 16'h0000, 8'h3c);
   endtask

   task automatic test_six_clock();
      expectRead(5'h02, 16'h0000, 8'h00);
      expectRead(5'h01, 16'h0000, 8'h10);
      model.setP33(1'b0);
      writeLoc(5'h12, 16'h0000, 8'h00, 5);
      check("writeDone", doneCnt[7:0], 8'h01);
      check("sixClockMode", {7'h0, sixClockMode}, 8'h01);
      model.setP33(1'b1);
      expectRead(5'h01, 16'h0000, 8'h00);
   endtask

   task automatic test_lock();
      writeLoc(5'h1f, 16'h0000, 8'h00, 5);
      check("securityBits", {5'h0, securityBits}, 8'h01);
      expectRead(5'h02, 16'h0000, 8'h80);
      expectRead(5'h03, 16'h0123, ~(8'h5a ^ 8'h0f));
      writeLoc(5'h1b, 16'h0200, 8'h11, 5);
      check("writeDone", doneCnt[7:0], 8'h00);
      writeLoc(5'h1a, 16'h0004, 8'h00, 5);
      check("writeDone", doneCnt[7:0], 8'h00);
      writeLoc(5'h1c, 16'h0000, 8'h00, 5);
      check("securityBits", {5'h0, securityBits}, 8'h03);
      expectRead(5'h02, 16'h0000, 8'hc0);
      model.setMode(5'h03, 16'h0123, 8'h00);
      check("port0Oe_n", {7'h0, port0Oe_n}, 8'h01);
      writeLoc(5'h15, 16'h0000, 8'h00, 5);
      check("securityBits", {5'h0, securityBits}, 8'h07);
      expectRead(5'h02, 16'h0000, 8'hc8);
   endtask

   task automatic give_verdict();
      $display("Compares %0d, miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      repeat (12) @(posedge clk);
      #1;
      reset_n = 1'b1;
      test_signature();
      test_code();
      test_key();
      test_six_clock();
      test_lock();
      give_verdict();
   end

   // Whole run needs well under 2000 cycles
   initial begin
      repeat (5000) @(posedge clk);
      miscompares++;
      give_verdict();
   end
endmodule
